//--- src/splc_pkg.sv
// package for the serial port lock and configuration register bank
// assumes a single 50 MHz clock domain and a register access port from the serial engine
package splc_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_PHASE_LOSS = 16'hEC00;
  localparam logic [15:0] ADDR_PORT_LOCK = 16'hEC01;
  localparam logic [15:0] ADDR_HARMONIC_SETUP = 16'hE900;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int THRESH_LSB = 0;
  localparam int THRESH_MSB = 2;
  localparam int LINE_LSB = 3;
  localparam int LINE_MSB = 7;
  localparam int EXTREF_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int TBASE_LSB = 8;
  localparam int TBASE_MSB = 9;
  localparam logic [2:0] THRESH_RST = 3'h7;
  localparam logic [4:0] LINE_RST = 5'h00;
  localparam logic [1:0] TBASE_RST = 2'h0;
  localparam logic EXTREF_RST = 1'b0;
  localparam logic [1:0] SS_TOGGLES = 2'h3;
  localparam logic [7:0] THRESH_DIV = 8'h08;
  localparam logic [7:0] LINE_RATE_HZ = 8'h32;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPLC_PH_A,
    SPLC_PH_B,
    SPLC_PH_C
  } splc_phase_t;

  typedef enum {
    SPLC_I2C_OPEN,
    SPLC_SPI_OPEN,
    SPLC_I2C_LOCKED,
    SPLC_SPI_LOCKED
  } splc_port_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } splc_req_t;

  typedef struct packed {
    logic [2:0] threshold;
    logic [4:0] line_count;
    logic ext_ref;
    logic [1:0] time_base_sel;
  } splc_cfg_t;

endpackage : splc_pkg

//--- src/splc_ss_sync.sv
// three flop synchroniser and edge detector for the slave select pin
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module splc_ss_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // pin and event
  input wire logic slave_select_pin,
  output logic ss_edge
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic stable;
  } splc_sync_t;

  splc_sync_t st_r;
  splc_sync_t st_nxt;

  // ----------------------------------------------------------------
  // sync chain; change accepted once second and third stage agree
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = slave_select_pin;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.stable = st_r.s3;
    end
  end

  // pin idles high, so reset to high avoids a false toggle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, stable: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end

  // a full low pulse counts as one toggle: taken on the rising edge
  assign ss_edge = st_nxt.stable & ~st_r.stable;

endmodule : splc_ss_sync

//--- src/splc_regs.sv
// What this block does
// - time-base code 10 or reserved 11 selects phase C voltage
// - time-base bits 9:8: code 00 phase A, code 01 phase B
// - threshold equals full scale times bits 2:0 over eight, reset 111
// - period is (line count bits 7:3 plus one)/50 s, reset zero
// - reference bit 0 clear selects internal, set selects external reference
// - unlocked, three slave select toggles switch the device to SPI
// - on I2C, writing lock bit 1 freezes I2C; toggles then ignored
// - on SPI, any write to the lock register locks SPI for good
// - locked port choice survives every power state change
//
// register bank for the serial port lock and measurement setup
// assumes the serial engine issues one-cycle read/write strobes on mclk
`timescale 1ns/1ps
module splc_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register access from the serial engine
  input wire splc_pkg::splc_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  // pins and system
  input wire logic slave_select_pin,
  input wire logic [1:0] power_state,
  // configuration out
  output splc_pkg::splc_cfg_t cfg,
  output splc_pkg::splc_phase_t time_base_phase,
  output logic [7:0] threshold_num,
  output logic [7:0] threshold_den,
  output logic [7:0] period_num,
  output logic [7:0] period_den,
  output logic spi_active,
  output logic port_locked
);

  typedef struct packed {
    splc_pkg::splc_cfg_t cfg;
    splc_pkg::splc_port_state_t port;
    logic [1:0] toggles;
    logic [15:0] rdata;
    logic rvalid;
  } splc_state_t;

  splc_state_t st_r;
  splc_state_t st_nxt;
  logic ss_edge;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic splc_pkg::splc_phase_t splc_phase_decode(input logic [1:0] code);
    case (code)
      2'h0: splc_phase_decode = splc_pkg::SPLC_PH_A;
      2'h1: splc_phase_decode = splc_pkg::SPLC_PH_B;
      default: splc_phase_decode = splc_pkg::SPLC_PH_C;
    endcase
  endfunction : splc_phase_decode

  function automatic logic splc_is_locked(input splc_pkg::splc_port_state_t p);
    splc_is_locked = (p == splc_pkg::SPLC_I2C_LOCKED) || (p == splc_pkg::SPLC_SPI_LOCKED);
  endfunction : splc_is_locked

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  splc_ss_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .slave_select_pin(slave_select_pin),
    .ss_edge(ss_edge)
  );

  // ----------------------------------------------------------------
  // next state: register writes, reads and port selection
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = req.rd;
    // register writes
    if (req.wr) begin
      case (req.addr)
        splc_pkg::ADDR_PHASE_LOSS: begin
          st_nxt.cfg.threshold = req.wdata[splc_pkg::THRESH_MSB:splc_pkg::THRESH_LSB];
          st_nxt.cfg.line_count = req.wdata[splc_pkg::LINE_MSB:splc_pkg::LINE_LSB];
        end
        splc_pkg::ADDR_PORT_LOCK: begin
          st_nxt.cfg.ext_ref = req.wdata[splc_pkg::EXTREF_BIT];
        end
        splc_pkg::ADDR_HARMONIC_SETUP: begin
          st_nxt.cfg.time_base_sel = req.wdata[splc_pkg::TBASE_MSB:splc_pkg::TBASE_LSB];
        end
        default: begin
        end
      endcase
    end
    // port selection; power_state is deliberately not an input here
    case (st_r.port)
      splc_pkg::SPLC_I2C_OPEN: begin
        if (req.wr && req.addr == splc_pkg::ADDR_PORT_LOCK && req.wdata[splc_pkg::LOCK_BIT]) begin
          st_nxt.port = splc_pkg::SPLC_I2C_LOCKED;
        end else if (ss_edge) begin
          if (st_r.toggles == splc_pkg::SS_TOGGLES - 2'h1) begin
            st_nxt.port = splc_pkg::SPLC_SPI_OPEN;
            st_nxt.toggles = 2'h0;
          end else begin
            st_nxt.toggles = st_r.toggles + 2'h1;
          end
        end
      end
      splc_pkg::SPLC_SPI_OPEN: begin
        if (req.wr && req.addr == splc_pkg::ADDR_PORT_LOCK) begin
          st_nxt.port = splc_pkg::SPLC_SPI_LOCKED;
        end
      end
      splc_pkg::SPLC_I2C_LOCKED: begin
        st_nxt.toggles = 2'h0;
      end
      splc_pkg::SPLC_SPI_LOCKED: begin
        st_nxt.toggles = 2'h0;
      end
      default: begin
        st_nxt.port = splc_pkg::SPLC_I2C_OPEN;
      end
    endcase
    // reads return stored fields; reserved bits as zero
    st_nxt.rdata = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        splc_pkg::ADDR_PHASE_LOSS: st_nxt.rdata = {8'h00, st_r.cfg.line_count, st_r.cfg.threshold};
        splc_pkg::ADDR_PORT_LOCK: st_nxt.rdata = {14'h0000, splc_is_locked(st_r.port), st_r.cfg.ext_ref};
        splc_pkg::ADDR_HARMONIC_SETUP: st_nxt.rdata = {6'h00, st_r.cfg.time_base_sel, 8'h00};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register; only reset clears the lock
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st_r.cfg.threshold <= splc_pkg::THRESH_RST;
      st_r.cfg.line_count <= splc_pkg::LINE_RST;
      st_r.cfg.ext_ref <= splc_pkg::EXTREF_RST;
      st_r.cfg.time_base_sel <= splc_pkg::TBASE_RST;
      st_r.port <= splc_pkg::SPLC_I2C_OPEN;
      st_r.toggles <= 2'h0;
      st_r.rdata <= 16'h0000;
      st_r.rvalid <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs; ratios kept as numerator/denominator for the dsp
  // ----------------------------------------------------------------
  assign cfg = st_r.cfg;
  assign rdata = st_r.rdata;
  assign rvalid = st_r.rvalid;
  assign time_base_phase = splc_phase_decode(st_r.cfg.time_base_sel);
  assign threshold_num = {5'h00, st_r.cfg.threshold};
  assign threshold_den = splc_pkg::THRESH_DIV;
  assign period_num = {3'h0, st_r.cfg.line_count} + 8'h01;
  assign period_den = splc_pkg::LINE_RATE_HZ;
  assign spi_active = (st_r.port == splc_pkg::SPLC_SPI_OPEN) || (st_r.port == splc_pkg::SPLC_SPI_LOCKED);
  assign port_locked = splc_is_locked(st_r.port);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // kept beside the port logic so that a silent port swap is caught where it happens
  // power_state feeds only the cover below: the port choice must not depend on it
  a_lock_holds: assert property (@(posedge mclk) disable iff (!reset_n)
    port_locked |=> port_locked && $stable(spi_active))
    else $error("locked port changed");
  a_i2c_lock_set: assert property (@(posedge mclk) disable iff (!reset_n)
    (!spi_active && !port_locked && req.wr && req.addr == splc_pkg::ADDR_PORT_LOCK && req.wdata[1])
      |=> port_locked && !spi_active)
    else $error("i2c lock not taken");
  a_spi_lock_set: assert property (@(posedge mclk) disable iff (!reset_n)
    (spi_active && !port_locked && req.wr && req.addr == splc_pkg::ADDR_PORT_LOCK) |=> port_locked && spi_active)
    else $error("spi lock not taken");
  a_no_spi_locked: assert property (@(posedge mclk) disable iff (!reset_n)
    (port_locked && !spi_active) |=> !spi_active)
    else $error("switched to spi after i2c lock");
  a_ss_ignored: assert property (@(posedge mclk) disable iff (!reset_n)
    (port_locked && !spi_active && ss_edge) |=> !spi_active && st_r.toggles == 2'h0)
    else $error("toggle counted after i2c lock");
  a_lock_rd: assert property (@(posedge mclk) disable iff (!reset_n)
    (req.rd && req.addr == splc_pkg::ADDR_PORT_LOCK) |=> rvalid && rdata[splc_pkg::LOCK_BIT] == $past(port_locked))
    else $error("lock state read back wrong");
  a_spi_entry: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(spi_active) |-> $past(ss_edge) && $past(st_r.toggles) == 2'h2)
    else $error("spi entered without three toggles");
  a_phase_c: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg.time_base_sel[1] |-> time_base_phase == splc_pkg::SPLC_PH_C)
    else $error("code 1x not phase c");
  a_phase_ab: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg.time_base_sel[1] |-> time_base_phase == splc_pkg::splc_phase_t'(cfg.time_base_sel))
    else $error("phase a/b decode wrong");
  a_thresh_wr: assert property (@(posedge mclk) disable iff (!reset_n)
    (req.wr && req.addr == splc_pkg::ADDR_PHASE_LOSS) |=> threshold_num == {5'h00, $past(req.wdata[2:0])})
    else $error("threshold not written");
  a_period_wr: assert property (@(posedge mclk) disable iff (!reset_n)
    (req.wr && req.addr == splc_pkg::ADDR_PHASE_LOSS) |=> period_num == {3'h0, $past(req.wdata[7:3])} + 8'h01)
    else $error("period not written");
  a_ref_wr: assert property (@(posedge mclk) disable iff (!reset_n)
    (req.wr && req.addr == splc_pkg::ADDR_PORT_LOCK) |=> cfg.ext_ref == $past(req.wdata[0]))
    else $error("reference select not written");
  a_reset_open: assert property (@(posedge mclk)
    !reset_n |=> !port_locked && !spi_active)
    else $error("reset did not clear lock");

  c_spi_switch: cover property (@(posedge mclk) disable iff (!reset_n) $rose(spi_active));
  c_spi_lock: cover property (@(posedge mclk) disable iff (!reset_n) $rose(port_locked) && spi_active);
  c_i2c_lock: cover property (@(posedge mclk) disable iff (!reset_n) $rose(port_locked) && !spi_active);
  c_psm_locked: cover property (@(posedge mclk) disable iff (!reset_n) port_locked && $changed(power_state));

endmodule : splc_regs

//--- tb/splc_host.sv
// host model: register strobes and slave select pin toggling
// assumes splc_regs answers a read one cycle after the strobe
`timescale 1ns/1ps
module splc_host (
  // clock
  input wire logic mclk,
  // register bus
  output splc_pkg::splc_req_t req,
  input wire logic [15:0] rdata,
  input wire logic rvalid,
  // pin
  output logic slave_select_pin
);
  // ----------------------------------------------------------------
  // bus and pin drivers
  // ----------------------------------------------------------------
  // pin idles high so that no toggle is counted at start
  initial begin
    req = '0;
    slave_select_pin = 1'b1;
  end

  // one-cycle write strobe; a lock write is how the host freezes I2C
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr

  // read data is taken in the cycle it stands, then dropped
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
    v = rvalid;
  endtask : rd

  // low phases of four cycles, high phases of five between pulses, above the synchroniser minimum
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge mclk);
      slave_select_pin <= 1'b0;
      repeat (4) @(posedge mclk);
      slave_select_pin <= 1'b1;
      repeat (4) @(posedge mclk);
    end
  endtask : toggle
endmodule : splc_host

//--- tb/tb_splc_regs.sv
// testbench for the serial port lock and configuration registers
// assumes the host model in splc_host.sv drives bus and pin
`timescale 1ns/1ps
module tb_splc_regs;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] power_state = 2'h0;
  splc_pkg::splc_req_t req;
  logic [15:0] rdata, d;
  logic rvalid, ss, spi_active, port_locked, v;
  splc_pkg::splc_cfg_t cfg;
  splc_pkg::splc_phase_t time_base_phase;
  logic [7:0] threshold_num, threshold_den, period_num, period_den;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #10 mclk = ~mclk;

  splc_regs DUT (.mclk(mclk), .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .slave_select_pin(ss), .power_state(power_state), .cfg(cfg), .time_base_phase(time_base_phase),
    .threshold_num(threshold_num), .threshold_den(threshold_den), .period_num(period_num),
    .period_den(period_den), .spi_active(spi_active), .port_locked(port_locked));
  splc_host host (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid), .slave_select_pin(ss));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // one edge for the registered outputs to land
  task automatic settle();
    @(posedge mclk);
    #1;
  endtask : settle

  task automatic do_reset();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    settle();
  endtask : do_reset

  // cut a hang short; the whole run needs under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults();
    check("threshold", {13'h0, cfg.threshold}, 16'h0007);
    check("threshold_den", {8'h00, threshold_den}, 16'h0008);
    check("period_num", {8'h00, period_num}, 16'h0001);
    check("period_den", {8'h00, period_den}, 16'h0032);
    check("ext_ref", {15'h0, cfg.ext_ref}, 16'h0000);
    check("port", {14'h0, spi_active, port_locked}, 16'h0000);
    $display("defaults done");
  endtask : t_defaults

  // boundary field values, readback and an unmapped read
  task automatic t_fields();
    host.wr(splc_pkg::ADDR_PHASE_LOSS, 16'h000A);
    settle();
    check("threshold_num", {8'h00, threshold_num}, 16'h0002);
    check("period_num", {8'h00, period_num}, 16'h0002);
    host.wr(splc_pkg::ADDR_PHASE_LOSS, 16'hFFFF);
    settle();
    check("threshold_num", {8'h00, threshold_num}, 16'h0007);
    check("period_num", {8'h00, period_num}, 16'h0020);
    host.rd(splc_pkg::ADDR_PHASE_LOSS, d, v);
    check("rdata", d, 16'h00FF);
    check("rvalid", {15'h0, v}, 16'h0001);
    host.rd(16'h1234, d, v);
    check("unmapped", d, 16'h0000);
    check("unmapped_valid", {15'h0, v}, 16'h0001);
    $display("fields done");
  endtask : t_fields

  // every time-base code, reserved upper bits set as well
  task automatic t_tbase();
    for (int i = 0; i < 4; i++) begin
      host.wr(splc_pkg::ADDR_HARMONIC_SETUP, 16'hFC00 | (16'(i) << 8));
      settle();
      check("phase", {14'h0, time_base_phase}, (i > 2) ? 16'h0002 : 16'(i));
    end
    host.rd(splc_pkg::ADDR_HARMONIC_SETUP, d, v);
    check("tbase_rd", d, 16'h0300);
    $display("time base done");
  endtask : t_tbase

  task automatic t_i2c_lock();
    host.wr(splc_pkg::ADDR_PORT_LOCK, 16'h0003);
    settle();
    check("lock", {14'h0, port_locked, cfg.ext_ref}, 16'h0003);
    host.toggle(3);
    repeat (6) settle();
    check("spi_active", {15'h0, spi_active}, 16'h0000);
    @(posedge mclk);
    power_state <= 2'h2;
    host.wr(splc_pkg::ADDR_PORT_LOCK, 16'h0000);
    settle();
    check("relock", {14'h0, port_locked, spi_active}, 16'h0002);
    host.rd(splc_pkg::ADDR_PORT_LOCK, d, v);
    check("lock_rd", d, 16'h0002);
    do_reset();
    check("unlock", {14'h0, spi_active, port_locked}, 16'h0000);
    $display("i2c lock done");
  endtask : t_i2c_lock

  // two toggles must not switch; the third must
  task automatic t_spi_lock();
    host.toggle(2);
    repeat (6) settle();
    check("spi_two", {15'h0, spi_active}, 16'h0000);
    host.toggle(1);
    repeat (6) settle();
    check("spi_three", {14'h0, spi_active, port_locked}, 16'h0002);
    host.wr(splc_pkg::ADDR_PORT_LOCK, 16'h0000);
    settle();
    check("spi_lock", {15'h0, port_locked}, 16'h0001);
    @(posedge mclk);
    power_state <= 2'h1;
    @(posedge mclk);
    power_state <= 2'h3;
    repeat (3) settle();
    check("spi_kept", {14'h0, spi_active, port_locked}, 16'h0003);
    do_reset();
    check("unlock", {14'h0, spi_active, port_locked}, 16'h0000);
    $display("spi lock done");
  endtask : t_spi_lock

  initial begin
    do_reset();
    t_defaults();
    t_fields();
    t_tbase();
    t_i2c_lock();
    t_spi_lock();
    report_and_stop();
  end
endmodule : tb_splc_regs
